//--- core/rail_seq_pkg.sv
/*
 rail_seq_pkg: constants, register map, field layout, timing counts and
 state types shared by the rail sequencer, its bus target and its slot stepper.
 assumes a single 40 MHz clock; all timing is derived from CLK_HZ below.
*/
package rail_seq_pkg;

	// clock and the 1 us step that paces every slot
	localparam int CLK_HZ = 40_000_000;
	localparam int HZ_PER_MHZ = 1_000_000;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = CLK_HZ / HZ_PER_MHZ * TICK_US;
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

	// 7-bit target address on the two-wire bus
	localparam logic [6:0] BUS_ADDR = 7'h38;

	// counts of controlled outputs
	localparam int NUM_BUCK = 4;
	localparam int NUM_LDO = 9;
	localparam int NUM_GPIO = 8;
	localparam int NUM_RAIL = NUM_BUCK + NUM_LDO;
	localparam int NUM_SEQ_OUT = NUM_RAIL + 5;
	localparam int NUM_REG = 57;
	localparam int UV_W = 22;

	// index of each register group inside the flop array
	localparam int IDX_BUCK_V = 0;
	localparam int IDX_BUCK_2 = 4;
	localparam int IDX_BUCK_3 = 8;
	localparam int IDX_LDO_V = 12;
	localparam int IDX_LDO_F = 21;
	localparam int IDX_GPIO = 30;
	localparam int IDX_SLOT = 38;
	localparam int IDX_DUR = 56;
	localparam int IDX_NONE = 127;

	// bus addresses of the first register of each group, and of the last buck register
	localparam logic [7:0] ADDR_BUCK_V = 8'h40;
	localparam logic [7:0] ADDR_BUCK_3_LAST = 8'h4b;
	localparam logic [7:0] ADDR_LDO_V = 8'h50;
	localparam logic [7:0] ADDR_LDO_F = 8'h60;
	localparam logic [7:0] ADDR_GPIO = 8'h70;
	localparam logic [7:0] ADDR_SLOT = 8'ha4;
	localparam logic [7:0] ADDR_DUR = 8'hb8;
	localparam logic [7:0] ADDR_STATUS = 8'hb9;

	// slot-assignment field positions
	localparam int SLOT_PD_LSB = 0;
	localparam int SLOT_PU_LSB = 3;
	localparam int SLOT_SRC_LSB = 6;
	// slot-duration field positions
	localparam int DUR_PD_LSB = 0;
	localparam int DUR_PU_LSB = 4;
	// general-purpose line configuration bits
	localparam int GPIO_PP_BIT = 0;
	localparam int GPIO_DIR_BIT = 1;
	localparam int GPIO_IN_BIT = 2;
	localparam int GPIO_LVL_BIT = 3;

	// reset values and write masks
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] GPIO_RESET = 8'h02;
	localparam logic [7:0] DUR_RESET = 8'h77;
	localparam logic [7:0] BUCK_LOW_MASK = 8'h7f;
	localparam logic [7:0] LDO_V_MASK = 8'h3f;
	localparam logic [7:0] GPIO_MASK = 8'hfb;
	localparam logic [7:0] FULL_MASK = 8'hff;

	// sequencer phase and bus target states
	typedef enum logic [1:0] {PH_OFF, PH_UP, PH_ON, PH_DOWN} phase_e;
	typedef enum logic [3:0] {
		B_IDLE, B_ADDR, B_ACK_ADDR, B_REG, B_ACK_REG, B_WDATA, B_ACK_W, B_RDATA, B_RACK
	} bus_state_e;

	// slot length in microseconds for a 3-bit code
	function automatic logic [11:0] slot_len_us(input logic [2:0] code);
		case (code)
			3'h0: slot_len_us = 12'd31;
			3'h1: slot_len_us = 12'd63;
			3'h2: slot_len_us = 12'd127;
			3'h3: slot_len_us = 12'd253;
			3'h4: slot_len_us = 12'd508;
			3'h5: slot_len_us = 12'd984;
			3'h6: slot_len_us = 12'd1936;
			default: slot_len_us = 12'd3904;
		endcase
	endfunction : slot_len_us

endpackage : rail_seq_pkg

//--- core/slot_stepper.sv
/*
 slot_stepper: one sequencer instance; walks eight slots up or down
 while its enable level rises or falls.
 assumes run is already synchronised and tick is a one-cycle 1 us pulse.
*/
`timescale 1ns/1ps
module slot_stepper (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic tick,
	input wire logic [11:0] pu_len_us,
	input wire logic [11:0] pd_len_us,
	// state
	output rail_seq_pkg::phase_e phase,
	output logic [2:0] slot
);
	import rail_seq_pkg::*;

	phase_e phase_q; // current phase
	logic [2:0] slot_q; // current slot
	logic [11:0] timer_q; // microseconds spent in slot
	logic [11:0] len; // length of the slot in force
	logic slot_end; // last microsecond of the slot

	// each direction has its own slot length
	assign len = (phase_q == PH_DOWN) ? pd_len_us : pu_len_us;
	assign slot_end = tick && (timer_q == len - 12'h001);
	assign phase = phase_q;
	assign slot = slot_q;

	// phase and slot walk; a change of enable restarts from slot 0 the other way
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_q <= PH_OFF;
			slot_q <= 3'h0;
			timer_q <= 12'h000;
		end else begin
			case (phase_q)
				PH_OFF: begin
					if (run) begin
						phase_q <= PH_UP;
						slot_q <= 3'h0;
						timer_q <= 12'h000;
					end
				end
				PH_UP, PH_DOWN: begin
					if (run != (phase_q == PH_UP)) begin
						// reversal mid-walk: start the opposite walk at its first slot
						phase_q <= run ? PH_UP : PH_DOWN;
						slot_q <= 3'h0;
						timer_q <= 12'h000;
					end else if (slot_end) begin
						timer_q <= 12'h000;
						if (slot_q == 3'h7) begin
							phase_q <= (phase_q == PH_UP) ? PH_ON : PH_OFF;
						end else begin
							slot_q <= slot_q + 3'h1;
						end
					end else if (tick) begin
						timer_q <= timer_q + 12'h001;
					end
				end
				PH_ON: begin
					if (!run) begin
						phase_q <= PH_DOWN;
						slot_q <= 3'h0;
						timer_q <= 12'h000;
					end
				end
				default: phase_q <= PH_OFF;
			endcase
		end
	end

endmodule : slot_stepper

//--- core/bus_target.sv
/*
 bus_target: two-wire bus target that writes and reads 8-bit registers
 through a byte pointer; the pointer advances after each acknowledged data byte.
 assumes scl and sda come from pins; both are synchronised here.
*/
`timescale 1ns/1ps
module bus_target (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe,
	// register port
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	import rail_seq_pkg::*;

	logic scl_s1, scl_s2, scl_s3; // scl synchroniser and history
	logic sda_s1, sda_s2, sda_s3; // sda synchroniser and history
	logic scl_rise, scl_fall, start_seen, stop_seen;
	bus_state_e st_q; // transfer state
	logic [3:0] cnt_q; // bits moved in the byte
	logic [7:0] sh_q; // shift register
	logic [7:0] ptr_q; // register pointer
	logic rw_q; // read transfer
	logic nack_q; // controller refused more data
	logic oe_q, wr_stb_q;
	logic [7:0] wr_addr_q, wr_data_q;

	// two flops before any edge logic; the third flop only keeps history
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
		end
	end

	assign scl_rise = scl_s2 && !scl_s3;
	assign scl_fall = !scl_s2 && scl_s3;
	assign start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign stop_seen = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
	assign sda_oe = oe_q;
	assign wr_stb = wr_stb_q;
	assign wr_addr = wr_addr_q;
	assign wr_data = wr_data_q;
	assign rd_addr = ptr_q;

	// address byte, register byte, then data bytes; sda changes only while scl is low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= B_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			oe_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (start_seen) begin
				st_q <= B_ADDR;
				cnt_q <= 4'h0;
				oe_q <= 1'b0;
			end else if (stop_seen) begin
				st_q <= B_IDLE;
				oe_q <= 1'b0;
			end else if (scl_rise) begin
				case (st_q)
					B_ADDR, B_REG, B_WDATA: begin
						sh_q <= {sh_q[6:0], sda_s2};
						cnt_q <= cnt_q + 4'h1;
					end
					B_RACK: begin
						nack_q <= sda_s2;
						if (!sda_s2) ptr_q <= ptr_q + 8'h01;
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				case (st_q)
					B_ADDR: if (cnt_q == 4'h8) begin
						if (sh_q[7:1] == BUS_ADDR) begin
							st_q <= B_ACK_ADDR;
							oe_q <= 1'b1;
							rw_q <= sh_q[0];
						end else begin
							st_q <= B_IDLE; // another target's transfer
						end
					end
					B_ACK_ADDR: begin
						if (rw_q) begin
							st_q <= B_RDATA;
							sh_q <= rd_data;
							oe_q <= !rd_data[7];
							cnt_q <= 4'h1;
						end else begin
							st_q <= B_REG;
							oe_q <= 1'b0;
							cnt_q <= 4'h0;
						end
					end
					B_REG: if (cnt_q == 4'h8) begin
						ptr_q <= sh_q;
						st_q <= B_ACK_REG;
						oe_q <= 1'b1;
					end
					B_ACK_REG, B_ACK_W: begin
						if (st_q == B_ACK_W) ptr_q <= ptr_q + 8'h01;
						st_q <= B_WDATA;
						oe_q <= 1'b0;
						cnt_q <= 4'h0;
					end
					B_WDATA: if (cnt_q == 4'h8) begin
						wr_stb_q <= 1'b1;
						wr_addr_q <= ptr_q;
						wr_data_q <= sh_q;
						st_q <= B_ACK_W;
						oe_q <= 1'b1;
					end
					B_RDATA: begin
						if (cnt_q == 4'h8) begin
							oe_q <= 1'b0;
							st_q <= B_RACK;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							oe_q <= !sh_q[6];
							cnt_q <= cnt_q + 4'h1;
						end
					end
					B_RACK: begin
						if (nack_q) begin
							st_q <= B_IDLE;
						end else begin
							st_q <= B_RDATA;
							sh_q <= rd_data;
							oe_q <= !rd_data[7];
							cnt_q <= 4'h1;
						end
					end
					default: ;
				endcase
			end
		end
	end

endmodule : bus_target

//--- core/rail_sequencer_boot_config.sv
/*
 rail_sequencer_boot_config: configuration registers of a power chip and
 the two rail sequencers that switch its outputs on and off slot by slot.
 assumes the configuring controller reaches it over the two-wire bus pins,
 and that the analog regulators act on the enables and codes driven here.
*/
//
// Operation
// - eight ordered slots, any output any slot
// - assignment bits 2:0 give power-down slot
// - assignment bits 5:3 give power-up slot
// - assignment bits 7:6 choose sequencer 0 or 1; the code decodes bit 6 only and ignores bit 7
// - enable pin 0 runs sequencer 0, pin 1 sequencer 1
// - bucks, ldos, lines 0,1,2,7, reset own assignments
// - duration register: down 2:0, up 6:4
// - length codes map 31 us to 3904 us
// - bucks 0,1: 0.26 V plus (code-1) 10 mV
// - buck 2: 0.6 V plus code 6.25 mV
// - buck 3: 0.6 V plus code 12.5 mV
// - buck second/third registers select ramp, discharge, modes
// - ldos 0,1: 0.8 V plus code 25 mV
// - ldo 4: 0.4 V plus code 12.5 mV
// - ldo second register: clamp, low power, discharge, startup
// - line register: direction, drive type, level, input options
// - sequencing uses the written values, not defaults
`timescale 1ns/1ps
module rail_sequencer_boot_config (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// two-wire configuration bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// sequencer enable pins
	input wire logic sequencer0_enable_pin,
	input wire logic sequencer1_enable_pin,
	// general-purpose lines
	input wire logic [rail_seq_pkg::NUM_GPIO-1:0] gpio_i,
	output logic [rail_seq_pkg::NUM_GPIO-1:0] gpio_o,
	output logic [rail_seq_pkg::NUM_GPIO-1:0] gpio_oe,
	// regulator enables, reset output and settings
	output logic [rail_seq_pkg::NUM_RAIL-1:0] rail_enable,
	output logic reset_out_n,
	output logic [3*rail_seq_pkg::NUM_BUCK*8-1:0] buck_cfg_image,
	output logic [2*rail_seq_pkg::NUM_LDO*8-1:0] ldo_cfg_image,
	output logic [rail_seq_pkg::NUM_RAIL*rail_seq_pkg::UV_W-1:0] rail_target_uv
);
	import rail_seq_pkg::*;

	// map a bus address to a flop index, IDX_NONE when unmapped
	function automatic logic [6:0] reg_index(input logic [7:0] a);
		if (a >= ADDR_BUCK_V && a <= ADDR_BUCK_3_LAST)
			reg_index = 7'(a - ADDR_BUCK_V) + 7'(IDX_BUCK_V);
		else if (a >= ADDR_LDO_V && a < ADDR_LDO_V + 8'(NUM_LDO))
			reg_index = 7'(a - ADDR_LDO_V) + 7'(IDX_LDO_V);
		else if (a >= ADDR_LDO_F && a < ADDR_LDO_F + 8'(NUM_LDO))
			reg_index = 7'(a - ADDR_LDO_F) + 7'(IDX_LDO_F);
		else if (a >= ADDR_GPIO && a < ADDR_GPIO + 8'(NUM_GPIO))
			reg_index = 7'(a - ADDR_GPIO) + 7'(IDX_GPIO);
		else if (a >= ADDR_SLOT && a < ADDR_SLOT + 8'(NUM_SEQ_OUT))
			reg_index = 7'(a - ADDR_SLOT) + 7'(IDX_SLOT);
		else if (a == ADDR_DUR)
			reg_index = 7'(IDX_DUR);
		else
			reg_index = 7'(IDX_NONE);
	endfunction : reg_index

	// bits that can be written in each register; the rest read as zero, except line bit 2, which reads the input
	function automatic logic [7:0] write_mask(input int i);
		if (i == IDX_BUCK_V || i == IDX_BUCK_V + 1)
			write_mask = BUCK_LOW_MASK;
		else if (i >= IDX_LDO_V && i < IDX_LDO_V + NUM_LDO)
			write_mask = LDO_V_MASK;
		else if (i >= IDX_GPIO && i < IDX_GPIO + NUM_GPIO)
			write_mask = GPIO_MASK;
		else
			write_mask = FULL_MASK;
	endfunction : write_mask

	// value after reset of each register
	function automatic logic [7:0] reset_value(input int i);
		if (i >= IDX_GPIO && i < IDX_GPIO + NUM_GPIO)
			reset_value = GPIO_RESET;
		else if (i == IDX_DUR)
			reset_value = DUR_RESET;
		else
			reset_value = CFG_RESET;
	endfunction : reset_value

	// target rail voltage in microvolts for a code
	function automatic logic [UV_W-1:0] target_uv(input int rail, input logic [7:0] code);
		int v;
		v = 0;
		case (rail)
			0, 1: v = 260_000 + (int'(code[6:0]) - 1) * 10_000;
			2: v = 600_000 + int'(code) * 6_250;
			3: v = 600_000 + int'(code) * 12_500;
			4, 5: v = 800_000 + int'(code[5:0]) * 25_000;
			8: v = 400_000 + int'(code[5:0]) * 12_500;
			default: v = 800_000 + int'(code[5:0]) * 50_000;
		endcase
		target_uv = v[UV_W-1:0];
	endfunction : target_uv

	logic [7:0] reg_q [NUM_REG]; // configuration flops
	logic wr_stb; // one-cycle write from the bus
	logic [7:0] wr_addr, wr_data, rd_addr;
	logic [7:0] rd_data; // read answer for the pointer
	logic [6:0] wr_idx, rd_idx;
	logic [1:0] en_s1, en_s2; // enable pin synchronisers
	logic [NUM_GPIO-1:0] gin_s1, gin_s2; // line input synchronisers
	logic [5:0] tick_cnt_q; // 1 us divider
	logic tick_q; // 1 us pulse
	phase_e phase [2]; // sequencer phases
	logic [2:0] slot [2]; // sequencer slots
	logic [11:0] pu_len_us, pd_len_us; // slot lengths in force
	logic [NUM_SEQ_OUT-1:0] out_on_d, out_on_q; // sequenced output state
	logic sda_o_q; // open-drain data always pulls low

	// bus target; are the controller's, this side only answers
	bus_target u_bus (
		.mclk(mclk),
		.rst(rst),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_oe(sda_oe),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	assign wr_idx = reg_index(wr_addr);
	assign rd_idx = reg_index(rd_addr);

	// register writes; a write takes effect on the next clock edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_REG; i++) reg_q[i] <= reset_value(i);
		end else if (wr_stb) begin
			for (int i = 0; i < NUM_REG; i++) begin
				if (wr_idx == 7'(i)) reg_q[i] <= wr_data & write_mask(i);
			end
		end
	end

	// read answer: line input level shows live, status gives the phases, other unmapped reads give zero
	always_comb begin
		rd_data = 8'h00;
		if (rd_addr == ADDR_STATUS) begin
			rd_data = {2'(phase[1]), 2'(phase[0]), 4'h0};
		end else if (rd_idx != 7'(IDX_NONE)) begin
			rd_data = reg_q[rd_idx[5:0]];
			if (rd_idx >= 7'(IDX_GPIO) && rd_idx < 7'(IDX_GPIO + NUM_GPIO))
				rd_data[GPIO_IN_BIT] = gin_s2[3'(rd_idx - 7'(IDX_GPIO))];
		end
	end

	// pins from outside pass two flops before use
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_s1 <= 2'h0;
			en_s2 <= 2'h0;
			gin_s1 <= '0;
			gin_s2 <= '0;
		end else begin
			en_s1 <= {sequencer1_enable_pin, sequencer0_enable_pin};
			en_s2 <= en_s1;
			gin_s1 <= gpio_i;
			gin_s2 <= gin_s1;
		end
	end

	// 1 us pacing pulse; slot timing is in whole microseconds
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_LAST);
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 6'h00 : tick_cnt_q + 6'h01;
		end
	end

	// slot lengths from the master duration register
	assign pd_len_us = slot_len_us(reg_q[IDX_DUR][DUR_PD_LSB +: 3]);
	assign pu_len_us = slot_len_us(reg_q[IDX_DUR][DUR_PU_LSB +: 3]);

	// two sequencers, each started by its own enable pin
	generate
		for (genvar s = 0; s < 2; s++) begin : g_seq
			slot_stepper u_step (
				.mclk(mclk),
				.rst(rst),
				.run(en_s2[s]),
				.tick(tick_q),
				.pu_len_us(pu_len_us),
				.pd_len_us(pd_len_us),
				.phase(phase[s]),
				.slot(slot[s])
			);
		end
	endgenerate

	// output state from its sequencer, its slots and the current slot
	always_comb begin
		out_on_d = '0;
		for (int k = 0; k < NUM_SEQ_OUT; k++) begin
			logic src;
			logic [2:0] pu_slot, pd_slot;
			src = reg_q[IDX_SLOT + k][SLOT_SRC_LSB];
			pu_slot = reg_q[IDX_SLOT + k][SLOT_PU_LSB +: 3];
			pd_slot = reg_q[IDX_SLOT + k][SLOT_PD_LSB +: 3];
			case (phase[src])
				PH_UP: out_on_d[k] = (pu_slot <= slot[src]);
				PH_ON: out_on_d[k] = 1'b1;
				PH_DOWN: out_on_d[k] = (pd_slot > slot[src]);
				default: out_on_d[k] = 1'b0;
			endcase
		end
	end

	// registered output state; rail enables and reset leave straight from these flops, lines 0,1,2,7 through their pad flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) out_on_q <= '0;
		else out_on_q <= out_on_d;
	end

	assign rail_enable = out_on_q[NUM_RAIL-1:0];
	assign reset_out_n = out_on_q[NUM_SEQ_OUT-1];

	// settings image for the regulators, driven straight from the flops
	generate
		for (genvar b = 0; b < 3 * NUM_BUCK; b++) begin : g_buck_img
			assign buck_cfg_image[b*8 +: 8] = reg_q[IDX_BUCK_V + b];
		end
		for (genvar l = 0; l < 2 * NUM_LDO; l++) begin : g_ldo_img
			assign ldo_cfg_image[l*8 +: 8] = reg_q[IDX_LDO_V + l];
		end
	endgenerate

	// registered target voltages, one per rail
	generate
		for (genvar r = 0; r < NUM_RAIL; r++) begin : g_uv
			logic [UV_W-1:0] uv_q;
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) uv_q <= '0;
				else uv_q <= target_uv(r, reg_q[(r < NUM_BUCK) ? IDX_BUCK_V + r : IDX_LDO_V + r - NUM_BUCK]);
			end
			assign rail_target_uv[r*UV_W +: UV_W] = uv_q;
		end
	endgenerate

	// general-purpose line pads; lines 0,1,2,7 are also gated by their slot
	generate
		for (genvar g = 0; g < NUM_GPIO; g++) begin : g_gpio
			localparam int SEQ_K = (g == 7) ? NUM_RAIL + 3 : NUM_RAIL + g % 3;
			localparam bit SEQUENCED = (g < 3) || (g == 7);
			logic o_q, oe_q, lvl;
			logic [7:0] cfg;
			assign cfg = reg_q[IDX_GPIO + g];
			// an unsequenced line follows its level bit at once, so line 4 can signal
			assign lvl = cfg[GPIO_LVL_BIT] & (SEQUENCED ? out_on_q[SEQ_K] : 1'b1);
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					o_q <= 1'b0;
					oe_q <= 1'b0;
				end else begin
					o_q <= lvl;
					// open drain only pulls low; push-pull drives both levels
					oe_q <= !cfg[GPIO_DIR_BIT] && (cfg[GPIO_PP_BIT] || !lvl);
				end
			end
			assign gpio_o[g] = o_q;
			assign gpio_oe[g] = oe_q;
		end
	endgenerate

	// the data pin is open drain, so its driven level is always low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) sda_o_q <= 1'b0;
		else sda_o_q <= 1'b0;
	end
	assign sda_o = sda_o_q;

endmodule : rail_sequencer_boot_config

//--- tb/rail_seq_asserts.sv
/* rail_seq_asserts: port checks of the rail sequencer.
 assumes bus clock low phases of 10+ mclk and a pulled-up data wire. */
`timescale 1ns/1ps
module rail_seq_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus and enable pins
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic sequencer0_enable_pin,
	input wire logic sequencer1_enable_pin,
	// outputs watched
	input wire logic [rail_seq_pkg::NUM_GPIO-1:0] gpio_oe,
	input wire logic [rail_seq_pkg::NUM_RAIL-1:0] rail_enable,
	input wire logic reset_out_n,
	input wire logic [rail_seq_pkg::NUM_RAIL*rail_seq_pkg::UV_W-1:0] rail_target_uv
);
	import rail_seq_pkg::*;
	logic any_up; // some pin asks for power
	logic all_up; // both pins ask for power
	assign any_up = sequencer0_enable_pin | sequencer1_enable_pin;
	assign all_up = sequencer0_enable_pin & sequencer1_enable_pin;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// pins as the stepper saw them after the sync flops
	sequence s_up_seen;
		$past(any_up, 3) || $past(any_up, 4);
	endsequence
	sequence s_down_seen;
		!$past(all_up, 3) || !$past(all_up, 4);
	endsequence
	// bus clock fell a few cycles ago and is still low
	sequence s_fell_before;
		!scl_i && ($past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5));
	endsequence
	AST_RESET_OFF: assert property ($fell(rst) |-> rail_enable == '0 && !reset_out_n)
		else $error("outputs not off after reset");
	// writes land while scl is low, so scl high isolates sequencing
	AST_RISE_CAUSE: assert property ((rail_enable & ~$past(rail_enable)) != '0 && scl_i
		|-> s_up_seen)
		else $error("rail rose with no enable pin");
	AST_FALL_CAUSE: assert property ((~rail_enable & $past(rail_enable)) != '0 && scl_i
		|-> s_down_seen)
		else $error("rail fell with pins high");
	AST_ACK_TIME: assert property ($rose(sda_oe) |-> s_fell_before)
		else $error("data pulled low off the clock fall");
	AST_SDA_STEADY: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data changed while clock high");
	AST_SDA_OPEN: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	AST_UV_WRITE: assert property ($changed(rail_target_uv) && $past(rail_target_uv) != '0
		|-> !scl_i)
		else $error("target voltage moved without a write");
	AST_GPIO_OE: assert property ($changed(gpio_oe[6:3]) |-> !scl_i)
		else $error("line drive moved without a write");
endmodule : rail_seq_asserts
bind rail_sequencer_boot_config rail_seq_asserts u_rail_seq_asserts (.mclk, .rst, .scl_i,
	.sda_o, .sda_oe, .sequencer0_enable_pin, .sequencer1_enable_pin, .gpio_oe, .rail_enable,
	.reset_out_n, .rail_target_uv);

//--- tb/cfg_main_model.sv
/* cfg_main_model: configuring controller, bit-bang bus main.
 assumes a pull-up on the data wire; paced by the bench clock. */
`timescale 1ns/1ps
module cfg_main_model (
	// pacing clock
	input wire logic mclk,
	// resolved data wire
	input wire logic sda,
	// bus clock, data pull-down, owner select
	output logic scl,
	output logic sda_low,
	output logic bus_owner_select
);
	import rail_seq_pkg::*;
	// idle released bus, owner select high hands it on
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		bus_owner_select = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask : wt
	// owner select: low takes the bus, high hands it on
	task automatic own(input logic v);
		bus_owner_select = v;
	endtask : own
	// data moves only mid-low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic s);
		wt(4);
		sda_low = !b;
		wt(10);
		scl = 1'b1;
		wt(10);
		s = sda;
		scl = 1'b0;
	endtask : bit_io
	// also serves as repeated start
	task automatic start();
		wt(4);
		sda_low = 1'b0;
		wt(10);
		scl = 1'b1;
		wt(10);
		sda_low = 1'b1;
		wt(10);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		wt(4);
		sda_low = 1'b1;
		wt(10);
		scl = 1'b1;
		wt(10);
		sda_low = 1'b0;
		wt(10);
	endtask : stop
	// msb first, then a released ack slot
	task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			r[i] = s;
		end
		bit_io(1'b1, nak);
	endtask : byte_io
	task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
		output logic nak);
		logic [7:0] r;
		logic n0, n1, n2;
		start();
		byte_io({dev, 1'b0}, r, n0);
		byte_io(ra, r, n1);
		byte_io(d, r, n2);
		stop();
		nak = n0 | n1 | n2;
	endtask : wr
	// last byte is refused so the target lets go
	task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic n0, n1, n2, n3;
		start();
		byte_io({BUS_ADDR, 1'b0}, r, n0);
		byte_io(ra, r, n1);
		start();
		byte_io({BUS_ADDR, 1'b1}, r, n2);
		byte_io(8'hff, d, n3);
		stop();
		nak = n0 | n1 | n2 | !n3;
	endtask : rd
endmodule : cfg_main_model

//--- tb/tb.sv
/* tb: register and sequencing checks of the rail sequencer.
 assumes the controller model and bound checker are compiled before it. */
`timescale 1ns/1ps
module tb;
	import rail_seq_pkg::*;
	localparam int SL = 31 * TICK_CYCLES; // shortest slot in cycles
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sequencer0_enable_pin = 1'b0;
	logic sequencer1_enable_pin = 1'b0;
	logic scl_i, sda_i, sda_o, sda_oe, m_low, owner, nak, reset_out_n;
	logic [NUM_GPIO-1:0] gpio_i, gpio_o, gpio_oe;
	logic [NUM_RAIL-1:0] rail_enable;
	logic [3*NUM_BUCK*8-1:0] buck_cfg_image;
	logic [2*NUM_LDO*8-1:0] ldo_cfg_image;
	logic [NUM_RAIL*UV_W-1:0] rail_target_uv;
	logic [7:0] rd;
	// voltage table: register, code, rail, microvolts
	logic [7:0] va [6] = '{8'h40, 8'h42, 8'h43, 8'h50, 8'h52, 8'h54};
	logic [7:0] vd [6] = '{8'had, 8'h10, 8'h04, 8'h3f, 8'h3f, 8'h3f};
	int vr [6] = '{0, 2, 3, 4, 6, 8};
	logic [21:0] vu [6] = '{22'haae60, 22'haae60, 22'h9eb10, 22'h243d58, 22'h3c45b0,
		22'h121eac};
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #12.5 mclk = ~mclk;
	// open-drain data with pull-up, controller pull-down behind the owner switch; lines pulled down when not driven
	assign sda_i = !(sda_oe | (m_low & !owner));
	assign gpio_i = gpio_o & gpio_oe;
	rail_sequencer_boot_config u_rail_sequencer_boot_config (.mclk, .rst, .scl_i, .sda_i,
		.sda_o, .sda_oe, .sequencer0_enable_pin, .sequencer1_enable_pin, .gpio_i, .gpio_o,
		.gpio_oe, .rail_enable, .reset_out_n, .buck_cfg_image, .ldo_cfg_image, .rail_target_uv);
	cfg_main_model u_cfg_main_model (.mclk, .sda(sda_i), .scl(scl_i), .sda_low(m_low),
		.bus_owner_select(owner));
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_cfg_main_model.wr(BUS_ADDR, a, d, nak);
		chk(nak, 32'h0);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		u_cfg_main_model.rd(a, rd, nak);
		chk({nak, rd}, {1'b0, e});
	endtask : rdc
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask : step
	// a hang counts as a mismatch
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			complete_run();
		end
	end
	initial begin
		step(8);
		rst = 1'b0;
		step(4);
		u_cfg_main_model.own(1'b0);
		rdc(ADDR_DUR, DUR_RESET);
		rdc(8'h74, GPIO_RESET);
		wr(ADDR_STATUS, 8'hff);
		rdc(ADDR_STATUS, 8'h00);
		rdc(8'h30, 8'h00);
		u_cfg_main_model.wr(7'h39, ADDR_SLOT, 8'h3f, nak);
		chk(nak, 32'h1);
		rdc(ADDR_SLOT, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			wr(va[i], vd[i]);
			step(4);
			chk(rail_target_uv[vr[i]*UV_W +: UV_W], vu[i]);
		end
		rdc(ADDR_BUCK_V, 8'h2d);
		wr(8'h44, 8'h5a);
		wr(8'h60, 8'ha5);
		step(4);
		chk(buck_cfg_image[39:32], 8'h5a);
		chk(ldo_cfg_image[79:72], 8'ha5);
		wr(8'h74, 8'h09);
		step(4);
		chk({gpio_oe[4], gpio_o[4]}, 2'b11);
		$display("test settings done");
		wr(ADDR_DUR, 8'h00);
		rdc(ADDR_DUR, 8'h00);
		wr(ADDR_SLOT, 8'h11);
		wr(ADDR_SLOT + 8'h1, 8'h00);
		wr(ADDR_SLOT + 8'h2, 8'h40);
		rdc(ADDR_SLOT, 8'h11);
		u_cfg_main_model.own(1'b1);
		sequencer0_enable_pin = 1'b1;
		step(12);
		chk({rail_enable[2:0], reset_out_n}, 4'b0101);
		step(2 * SL - 62);
		chk(rail_enable[0], 1'b0);
		step(100);
		chk(rail_enable[0], 1'b1);
		$display("test power-up done");
		sequencer1_enable_pin = 1'b1;
		step(12);
		chk(rail_enable[2], 1'b1);
		sequencer0_enable_pin = 1'b0;
		sequencer1_enable_pin = 1'b0;
		step(12);
		chk({rail_enable[2:0], reset_out_n}, 4'b0010);
		step(SL - 74);
		chk(rail_enable[0], 1'b1);
		step(110);
		chk(rail_enable[0], 1'b0);
		u_cfg_main_model.own(1'b0);
		rdc(8'h74, 8'h0d);
		$display("test power-down done");
		complete_run();
	end
endmodule : tb
